// [pkg/rsq_pkg.sv]
// Shared constants, types and helpers for the reset sequencer.
package rsq_pkg;

    // Clock timing: ref_clk is the crystal clock, the system clock is half of it.
    localparam int CRYSTAL_CLOCK_PERIOD_NS = 20;
    localparam int SYS_DIV = 2;

    // Timing figures, counted in crystal clocks unless named otherwise.
    localparam int FILTER_TPC = 4;
    localparam int LATCH_TPC = 5;
    localparam int HOLD_TPC = 18;
    localparam int SETTLE_SYS_CLOCKS = 4;
    localparam int SETTLE_TPC = SETTLE_SYS_CLOCKS * SYS_DIV;
    localparam int EXEC_DELAY_MIN_TPC = 5;
    localparam int EXEC_DELAY_MAX_TPC = 10;
    localparam int EXEC_DELAY_TPC = EXEC_DELAY_MIN_TPC;

    // Power-on hold time; a plain default, tuned per product.
    localparam int POWER_ON_HOLD_TIME_US = 1000;

    // Least time in ns to whole clock cycles, rounded up.
    function automatic int cycles_ceil(input int time_ns);
        int c;
        c = (time_ns + CRYSTAL_CLOCK_PERIOD_NS - 1) / CRYSTAL_CLOCK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int POWER_ON_HOLD_CYC = cycles_ceil(POWER_ON_HOLD_TIME_US * 1000);

    // Fetch vector loaded into the program counter on every reset.
    localparam logic [15:0] RESET_VECTOR = 16'h000C;

    // Control register offsets.
    localparam logic [7:0] OFS_TIMER_MODE = 8'hF1;
    localparam logic [7:0] OFS_T1_PRESCALE = 8'hF3;
    localparam logic [7:0] OFS_T0_PRESCALE = 8'hF5;
    localparam logic [7:0] OFS_P2_MODE = 8'hF6;
    localparam logic [7:0] OFS_P3_MODE = 8'hF7;
    localparam logic [7:0] OFS_P01_MODE = 8'hF8;
    localparam logic [7:0] OFS_IRQ_REQ = 8'hFA;
    localparam logic [7:0] OFS_IRQ_MASK = 8'hFB;
    localparam logic [7:0] OFS_REG_PTR = 8'hFD;
    localparam logic [7:0] OFS_CAUSE = 8'h10;
    localparam logic [7:0] OFS_SEQ_CTRL = 8'h11;
    localparam logic [7:0] OFS_GP_BASE = 8'h20;
    localparam int GP_DEPTH = 16;

    // Values after a restoring reset; masks keep the bits with unknown reset state.
    localparam logic [7:0] RST_TIMER_MODE = 8'h00;
    localparam logic [7:0] KEEP_T1_PRESCALE = 8'hFC;
    localparam logic [7:0] KEEP_T0_PRESCALE = 8'hFE;
    localparam logic [7:0] RST_P2_MODE = 8'hFF;
    localparam logic [7:0] RST_P3_MODE = 8'h00;
    localparam logic [7:0] RST_P01_MODE = 8'h4D;
    localparam logic [7:0] RST_IRQ_REQ = 8'h00;
    localparam logic [7:0] KEEP_IRQ_MASK = 8'h7F;
    localparam logic [7:0] RST_REG_PTR = 8'h00;
    localparam logic [7:0] RST_SEQ_CTRL = 8'h03;

    // Cause and sequencer-control bit positions.
    localparam int CAUSE_POR = 0;
    localparam int CAUSE_PIN = 1;
    localparam int CAUSE_WDT = 2;
    localparam int CAUSE_STOP = 3;
    localparam int CTRL_WDT_EN = 0;
    localparam int CTRL_STOP_POR = 1;

    // Sequencer states.
    typedef enum logic [1:0] {
        ST_RUN,
        ST_LATCH,
        ST_HOLD,
        ST_START
    } rsq_state_e;

    // Control registers that reset restores.
    typedef struct packed {
        logic [7:0] timer_mode;
        logic [7:0] t1_prescale;
        logic [7:0] t0_prescale;
        logic [7:0] p2_mode;
        logic [7:0] p3_mode;
        logic [7:0] p01_mode;
        logic [7:0] irq_req;
        logic [7:0] irq_mask;
        logic [7:0] reg_ptr;
    } rsq_ctrl_s;

    // External bus strobes.
    typedef struct packed {
        logic addr_strobe;
        logic data_strobe_n;
        logic rd_wr_n;
    } rsq_strobe_s;

endpackage

// [src/rsq_filter.sv]
// Reset pin synchroniser and low-pulse noise filter.
`timescale 1ns/1ns
`default_nettype none
module rsq_filter import rsq_pkg::*; (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Pin side
    input wire logic reset_pin_n,
    // Filtered results
    output logic pin_low,
    output logic pin_det
);

    logic sync1_q, sync2_q;
    logic [2:0] low_cnt_q, low_cnt_d;

    // Low samples are counted after the second stage.
    always_comb begin
        low_cnt_d = low_cnt_q;
        if (sync2_q) begin
            low_cnt_d = 3'h0;
        end else if (low_cnt_q != 3'(FILTER_TPC)) begin
            low_cnt_d = low_cnt_q + 3'h1;
        end
    end

    // R9: pin synchronised here.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            low_cnt_q <= 3'h0;
        end else begin
            sync1_q <= reset_pin_n;
            sync2_q <= sync1_q;
            low_cnt_q <= low_cnt_d;
        end
    end

    assign pin_low = ~sync2_q;
    // R13: short pulses ignored.
    assign pin_det = (low_cnt_q == 3'(FILTER_TPC));

endmodule
`default_nettype wire

// [src/rsq_hold.sv]
// Reset hold counter, stretched while the pin stays low.
`timescale 1ns/1ns
`default_nettype none
module rsq_hold import rsq_pkg::*; (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Control
    input wire logic start,
    input wire logic [23:0] load,
    input wire logic extend,
    // Status
    output logic busy
);

    logic [23:0] cnt_q, cnt_d;

    // Counts the loaded span down; a start restarts it at once.
    always_comb begin
        cnt_d = cnt_q;
        if (start) begin
            cnt_d = load - 24'h1;
        end else if (cnt_q != 24'h0) begin
            cnt_d = cnt_q - 24'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cnt_q <= 24'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // R14: longer of count or pin.
    assign busy = (cnt_q != 24'h0) || start || extend;

endmodule
`default_nettype wire

// [src/rsq_top.sv]
// Reset sequencer top: sources, sequence, strobes and control registers.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// R1: Four sources reset: power-on, pin, watchdog, stop.
// R2: Partner holds pin low 21 SYSTEM_CLOCK_PERIOD/5 Crystal_clock_period.
// R3: Power-on, pin, run/halt watchdog restore defaults.
// R4: Stop recovery or stop watchdog keep registers.
// R5: In reset strobe toggles, data low, write high.
// R6: Program counter loads vector 000C on reset.
// R7: General-purpose registers never touched by reset.
// R8: Execution starts 5 to 10 clocks after release.
// R9: Pin input synchronised to the clock.
// R10: Internal circuitry reset within 4 system clocks.
// R11: Power-on hold drives reset pin low.
// R12: Other drivers of the pin are open-drain.
// R13: Pin lows shorter than 4 Crystal_clock_period ignored.
// R14: Latch on fifth clock, hold 18 or longer.
// R15: Timer prescalers reset to single-pass, external.
// R16: Port 2 mode ones, port 3 mode zeros.
// R17: Port 0-1 mode: internal stack, normal timing.
// R18: Ports 0,1 push-pull inputs, port 2 open-drain.
// R19: Watchdog retriggers power-on hold like power-on.
// R20: Assert at once, release synchronously after hold.
module rsq_top import rsq_pkg::*; #(
    parameter int POR_HOLD_CYCLES = POWER_ON_HOLD_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Reset pin, open-drain
    input wire logic reset_pin_n_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    // Other reset sources
    input wire logic power_ok,
    input wire logic wdt_timeout,
    input wire logic stop_recovery,
    input wire logic stop_mode,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Core and bus side
    output logic rst_int,
    output logic exec_start,
    output logic [15:0] pc_vector,
    output rsq_strobe_s strobes,
    output rsq_ctrl_s ctrl
);

    rsq_state_e state_q, state_d;
    logic [3:0] seq_cnt_q, seq_cnt_d;
    logic rst_int_q, rst_int_d;
    logic restore_q, restore_d;
    logic por_q, por_d;
    logic exec_start_q, exec_start_d;
    logic [15:0] pc_q, pc_d;
    logic pin_oe_q, pin_oe_d;
    logic sys_div_q, sys_div_d;
    rsq_strobe_s strobe_q, strobe_d;
    rsq_ctrl_s ctrl_q, ctrl_d;
    logic [7:0] seq_ctrl_q, seq_ctrl_d;
    logic [3:0] cause_q, cause_d;
    logic [7:0] rdata_q, rdata_d;
    logic power_ok_q;
    logic [7:0] gp_mem [GP_DEPTH];

    logic pin_low, pin_det, hold_busy, hold_start;
    logic [23:0] hold_load;
    logic req_por, req_pin, req_wdt, req_stop, any_req;
    logic evt_restore, evt_por, apply_defaults;
    logic [3:0] cause_set, cause_clr;
    logic bus_wr;

    rsq_filter u_filter (
        .ref_clk(ref_clk),
        .reset(reset),
        .reset_pin_n(reset_pin_n_in || pin_oe_q), // Own pull is not a request.
        .pin_low(pin_low),
        .pin_det(pin_det)
    );

    rsq_hold u_hold (
        .ref_clk(ref_clk),
        .reset(reset),
        .start(hold_start),
        .load(hold_load),
        .extend(pin_low),
        .busy(hold_busy)
    );

    // R1: source requests combined.
    always_comb begin
        req_por = power_ok && !power_ok_q;
        req_pin = pin_det;
        req_wdt = wdt_timeout && seq_ctrl_q[CTRL_WDT_EN];
        req_stop = stop_recovery;
        any_req = req_por || req_pin || req_wdt || req_stop;
        // R3: restoring sources.
        // R4: stop-mode events excluded.
        evt_restore = req_por || req_pin || (req_wdt && !stop_mode);
        // R19: watchdog retriggers hold timer.
        evt_por = req_por || req_wdt || (req_stop && seq_ctrl_q[CTRL_STOP_POR]);
    end

    // Sequence of latch, hold and start; a request in latch or hold only widens it, one in start restarts it.
    always_comb begin
        state_d = state_q;
        seq_cnt_d = seq_cnt_q;
        rst_int_d = rst_int_q;
        restore_d = restore_q;
        por_d = por_q;
        exec_start_d = 1'b0;
        pc_d = pc_q;
        hold_start = 1'b0;
        hold_load = 24'(HOLD_TPC);
        apply_defaults = 1'b0;
        case (state_q)
            ST_RUN, ST_START: begin
                if (any_req) begin
                    // R20: assert at once.
                    state_d = ST_LATCH;
                    seq_cnt_d = 4'h0;
                    rst_int_d = 1'b1;
                    restore_d = evt_restore;
                    por_d = evt_por;
                end else if (state_q == ST_START) begin
                    // R8: delayed execution start.
                    if (seq_cnt_q == 4'(EXEC_DELAY_TPC - 1)) begin
                        state_d = ST_RUN;
                        exec_start_d = 1'b1;
                    end else begin
                        seq_cnt_d = seq_cnt_q + 4'h1;
                    end
                end
            end
            ST_LATCH: begin
                restore_d = restore_q || evt_restore;
                por_d = por_q || evt_por;
                // R14: fifth clock latch.
                if (seq_cnt_q == 4'(LATCH_TPC - 1)) begin
                    state_d = ST_HOLD;
                    hold_start = 1'b1;
                    // R11: power-on span chosen.
                    hold_load = (por_q || evt_por) ? 24'(POR_HOLD_CYCLES) : 24'(HOLD_TPC);
                    // R10: settle inside the hold.
                    apply_defaults = restore_q || evt_restore;
                    // R6: vector loaded.
                    pc_d = RESET_VECTOR;
                end else begin
                    seq_cnt_d = seq_cnt_q + 4'h1;
                end
            end
            ST_HOLD: begin
                if (evt_por) begin
                    hold_start = 1'b1;
                    hold_load = 24'(POR_HOLD_CYCLES);
                    por_d = 1'b1;
                end else if (!hold_busy) begin
                    // R20: synchronous release.
                    state_d = ST_START;
                    seq_cnt_d = 4'h0;
                    rst_int_d = 1'b0;
                    restore_d = 1'b0;
                    por_d = 1'b0;
                end
            end
            default: begin
                state_d = ST_LATCH;
                seq_cnt_d = 4'h0;
                rst_int_d = 1'b1;
            end
        endcase
    end

    // Pin drive and bus strobes follow the next reset level.
    always_comb begin
        sys_div_d = ~sys_div_q;
        // R11: pin pulled low.
        pin_oe_d = rst_int_d && por_d;
        if (rst_int_d) begin
            // R5: strobe levels in reset.
            strobe_d.addr_strobe = sys_div_q ? ~strobe_q.addr_strobe : strobe_q.addr_strobe;
            strobe_d.data_strobe_n = 1'b0;
            strobe_d.rd_wr_n = 1'b1;
        end else begin
            strobe_d.addr_strobe = 1'b1;
            strobe_d.data_strobe_n = 1'b1;
            strobe_d.rd_wr_n = 1'b1;
        end
    end

    // Control register writes are ignored while reset holds the core; cause clears and scratch writes still take effect.
    assign bus_wr = reg_wr && !rst_int_q;

    // Control registers: defaults win over a write in the same cycle.
    always_comb begin
        ctrl_d = ctrl_q;
        seq_ctrl_d = seq_ctrl_q;
        if (bus_wr) begin
            case (reg_addr)
                OFS_TIMER_MODE: ctrl_d.timer_mode = reg_wdata;
                OFS_T1_PRESCALE: ctrl_d.t1_prescale = reg_wdata;
                OFS_T0_PRESCALE: ctrl_d.t0_prescale = reg_wdata;
                OFS_P2_MODE: ctrl_d.p2_mode = reg_wdata;
                OFS_P3_MODE: ctrl_d.p3_mode = reg_wdata;
                OFS_P01_MODE: ctrl_d.p01_mode = reg_wdata;
                OFS_IRQ_REQ: ctrl_d.irq_req = reg_wdata;
                OFS_IRQ_MASK: ctrl_d.irq_mask = reg_wdata;
                OFS_REG_PTR: ctrl_d.reg_ptr = reg_wdata;
                OFS_SEQ_CTRL: seq_ctrl_d = reg_wdata;
                default: ctrl_d = ctrl_q;
            endcase
        end
        if (apply_defaults) begin
            ctrl_d.timer_mode = RST_TIMER_MODE;
            // R15: prescaler low bits cleared.
            ctrl_d.t1_prescale = ctrl_q.t1_prescale & KEEP_T1_PRESCALE;
            ctrl_d.t0_prescale = ctrl_q.t0_prescale & KEEP_T0_PRESCALE;
            // R16: port 2 and 3 modes.
            // R18: port 2 open-drain inputs.
            ctrl_d.p2_mode = RST_P2_MODE;
            ctrl_d.p3_mode = RST_P3_MODE;
            // R17: stack and timing mode.
            ctrl_d.p01_mode = RST_P01_MODE;
            ctrl_d.irq_req = RST_IRQ_REQ;
            ctrl_d.irq_mask = ctrl_q.irq_mask & KEEP_IRQ_MASK;
            ctrl_d.reg_ptr = RST_REG_PTR;
            seq_ctrl_d = RST_SEQ_CTRL;
        end
    end

    // Cause flags: a new event beats a write-one clear in the same cycle.
    always_comb begin
        cause_set = 4'h0;
        cause_set[CAUSE_POR] = req_por;
        cause_set[CAUSE_PIN] = req_pin;
        cause_set[CAUSE_WDT] = req_wdt;
        cause_set[CAUSE_STOP] = req_stop;
        cause_clr = (reg_wr && reg_addr == OFS_CAUSE) ? reg_wdata[3:0] : 4'h0;
        cause_d = (cause_q & ~cause_clr) | cause_set;
    end

    // Read data stand one cycle after the strobe.
    always_comb begin
        rdata_d = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                OFS_TIMER_MODE: rdata_d = ctrl_q.timer_mode;
                OFS_T1_PRESCALE: rdata_d = ctrl_q.t1_prescale;
                OFS_T0_PRESCALE: rdata_d = ctrl_q.t0_prescale;
                OFS_P2_MODE: rdata_d = ctrl_q.p2_mode;
                OFS_P3_MODE: rdata_d = ctrl_q.p3_mode;
                OFS_P01_MODE: rdata_d = ctrl_q.p01_mode;
                OFS_IRQ_REQ: rdata_d = ctrl_q.irq_req;
                OFS_IRQ_MASK: rdata_d = ctrl_q.irq_mask;
                OFS_REG_PTR: rdata_d = ctrl_q.reg_ptr;
                OFS_CAUSE: rdata_d = {4'h0, cause_q};
                OFS_SEQ_CTRL: rdata_d = seq_ctrl_q;
                default: begin
                    if (reg_addr[7:4] == OFS_GP_BASE[7:4]) begin
                        rdata_d = gp_mem[reg_addr[3:0]];
                    end
                end
            endcase
        end
    end

    // R7: scratch memory has no reset.
    always_ff @(posedge ref_clk) begin
        if (reg_wr && reg_addr[7:4] == OFS_GP_BASE[7:4]) begin
            gp_mem[reg_addr[3:0]] <= reg_wdata;
        end
    end

    // System reset counts as a cold start.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q <= ST_LATCH;
            seq_cnt_q <= 4'h0;
            rst_int_q <= 1'b1;
            restore_q <= 1'b1;
            por_q <= 1'b1;
            exec_start_q <= 1'b0;
            pc_q <= RESET_VECTOR;
            pin_oe_q <= 1'b1;
            sys_div_q <= 1'b0;
            strobe_q <= '{addr_strobe: 1'b1, data_strobe_n: 1'b0, rd_wr_n: 1'b1};
            ctrl_q <= '{RST_TIMER_MODE, 8'h00, 8'h00, RST_P2_MODE, RST_P3_MODE,
                        RST_P01_MODE, RST_IRQ_REQ, 8'h00, RST_REG_PTR};
            seq_ctrl_q <= RST_SEQ_CTRL;
            cause_q <= 4'h1;
            rdata_q <= 8'h00;
            power_ok_q <= 1'b1;
        end else begin
            state_q <= state_d;
            seq_cnt_q <= seq_cnt_d;
            rst_int_q <= rst_int_d;
            restore_q <= restore_d;
            por_q <= por_d;
            exec_start_q <= exec_start_d;
            pc_q <= pc_d;
            pin_oe_q <= pin_oe_d;
            sys_div_q <= sys_div_d;
            strobe_q <= strobe_d;
            ctrl_q <= ctrl_d;
            seq_ctrl_q <= seq_ctrl_d;
            cause_q <= cause_d;
            rdata_q <= rdata_d;
            power_ok_q <= power_ok;
        end
    end

    // The pin is only ever pulled low, so any open-drain partner can share it.
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe = pin_oe_q;
    assign reg_rdata = rdata_q;
    assign rst_int = rst_int_q;
    assign exec_start = exec_start_q;
    assign pc_vector = pc_q;
    assign strobes = strobe_q;
    assign ctrl = ctrl_q;

endmodule
`default_nettype wire

// [tb/rsq_top_chk.sv]
// Concurrent checks on the reset sequencer top ports.
`timescale 1ns/1ns
`default_nettype none
module rsq_top_chk import rsq_pkg::*; #(
    parameter int POR_HOLD_CYCLES = 20
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Pin and sources
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe,
    input wire logic power_ok,
    input wire logic stop_recovery,
    // Register read
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Core and bus side
    input wire logic rst_int,
    input wire logic exec_start,
    input wire logic [15:0] pc_vector,
    input wire rsq_strobe_s strobes
);
    logic [15:0] run_cnt_q, run_cnt_d;
    logic por_q, por_d;

    // Reset run length; por_q marks the first run after a cold start.
    always_comb begin
        run_cnt_d = rst_int ? run_cnt_q + 16'h0001 : 16'h0000;
        por_d = por_q && rst_int;
    end

    // Registers only.
    always_ff @(posedge ref_clk) begin
        run_cnt_q <= reset ? 16'h0000 : run_cnt_d;
        por_q <= reset ? 1'b1 : por_d;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_release;
        $fell(rst_int);
    endsequence
    sequence s_start_pulse;
        (!rst_int && pc_vector == RESET_VECTOR) ##1 !exec_start;
    endsequence

    property p_bus_in_reset;
        rst_int |-> !strobes.data_strobe_n && strobes.rd_wr_n;
    endproperty
    a_bus_in_reset: assert property (p_bus_in_reset)
        else $error("strobes wrong in reset");
    property p_as_toggle;
        rst_int [*4] |-> strobes.addr_strobe != $past(strobes.addr_strobe, 2);
    endproperty
    a_as_toggle: assert property (p_as_toggle)
        else $error("address strobe stalled");
    property p_exec_delay;
        s_release |-> ##[4:10] exec_start;
    endproperty
    a_exec_delay: assert property (p_exec_delay)
        else $error("start out of window");
    property p_start;
        exec_start |-> s_start_pulse;
    endproperty
    a_start: assert property (p_start)
        else $error("start pulse or vector wrong");
    property p_stop_fast;
        stop_recovery && !rst_int |=> rst_int;
    endproperty
    a_stop_fast: assert property (p_stop_fast)
        else $error("stop recovery missed");
    property p_power_fast;
        $rose(power_ok) && !rst_int |=> rst_int;
    endproperty
    a_power_fast: assert property (p_power_fast)
        else $error("power-on missed");
    property p_pin_drive;
        reset_pin_oe |-> !reset_pin_out && rst_int;
    endproperty
    a_pin_drive: assert property (p_pin_drive)
        else $error("pin drive wrong");
    property p_hold_min;
        s_release |-> run_cnt_q >= 16'h0017;
    endproperty
    a_hold_min: assert property (p_hold_min)
        else $error("reset too short");
    property p_por_hold;
        $fell(rst_int) && por_q |-> run_cnt_q >= 5 + POR_HOLD_CYCLES;
    endproperty
    a_por_hold: assert property (p_por_hold)
        else $error("power-on hold too short");
    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not idle");
endmodule
`default_nettype wire

// [tb/rsq_supervisor.sv]
// Model of an external open-drain reset supervisor.
`timescale 1ns/1ns
`default_nettype none
module rsq_supervisor (
    // Clock
    input wire logic ref_clk,
    // Command from the bench
    input wire logic go,
    input wire logic [7:0] low_len,
    // Pull on the line, never a high drive
    output logic pull_low
);
    logic [7:0] cnt_q = 8'h00;

    // pull low, release
    // Released, the line floats up on its pull-up; it never drives high.
    always @(posedge ref_clk) begin
        if (go) begin
            cnt_q <= low_len;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
    assign pull_low = (cnt_q != 8'h00);
endmodule
`default_nettype wire

// [tb/rsq_top_bench.sv]
// Self-checking bench for the reset sequencer top.
`timescale 1ns/1ns
`default_nettype none
module rsq_top_bench import rsq_pkg::*; ;
    localparam int POR_SIM = 20;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic power_ok = 1'b1, wdt_timeout = 1'b0, stop_recovery = 1'b0, stop_mode = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_val, sup_len = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0, sup_go = 1'b0;
    logic rst_int, exec_start, pin_out, pin_oe, pin_level, sup_low;
    logic [15:0] pc_vector;
    rsq_strobe_s strobes;
    rsq_ctrl_s ctrl;
    int bad_count = 0, checks = 0, rst_len = 0;
    logic [7:0] d_addr [11] = '{8'hF1, 8'hF3, 8'hF5, 8'hF6, 8'hF7, 8'hF8, 8'hFA, 8'hFB,
        8'hFD, 8'h11, 8'h05};
    logic [7:0] d_mask [11] = '{8'hFF, 8'h03, 8'h01, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h80,
        8'hFF, 8'hFF, 8'hFF};
    logic [7:0] d_val [11] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h4D, 8'h00, 8'h00,
        8'h00, 8'h03, 8'h00};
    logic [7:0] s_p2 [4] = '{8'hFF, 8'hFF, 8'h12, 8'h12};
    logic [7:0] s_cause [4] = '{8'h01, 8'h04, 8'h04, 8'h08};

    // Open-drain line with a pull-up.
    assign pin_level = !(sup_low || (pin_oe && !pin_out));
    always #10 ref_clk = ~ref_clk;
    // Reset run length, cleared by the tests.
    always @(posedge ref_clk) if (rst_int === 1'b1) rst_len <= rst_len + 1;

    rsq_top #(.POR_HOLD_CYCLES(POR_SIM)) dut (.ref_clk(ref_clk), .reset(reset),
        .reset_pin_n_in(pin_level), .reset_pin_out(pin_out), .reset_pin_oe(pin_oe),
        .power_ok(power_ok), .wdt_timeout(wdt_timeout), .stop_recovery(stop_recovery),
        .stop_mode(stop_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rst_int(rst_int), .exec_start(exec_start),
        .pc_vector(pc_vector), .strobes(strobes), .ctrl(ctrl));
    rsq_supervisor sup (.ref_clk(ref_clk), .go(sup_go), .low_len(sup_len),
        .pull_low(sup_low));

    task automatic compare8(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic compare_bit(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge ref_clk);
        reg_addr <= addr;
        reg_wdata <= data;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
        @(posedge ref_clk);
        reg_addr <= addr;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        data = reg_rdata;
    endtask
    // Bounded wait; a stuck reset counts as a mismatch.
    task automatic wait_exec();
        int n = 0;
        while (exec_start !== 1'b1 && n < 3000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        compare_bit("exec start", 1'b1, exec_start);
        compare8("pc vector", RESET_VECTOR, pc_vector);
    endtask
    task automatic pin_pulse(input logic [7:0] len);
        @(posedge ref_clk);
        sup_len <= len;
        sup_go <= 1'b1;
        @(posedge ref_clk);
        sup_go <= 1'b0;
    endtask
    // Source 0 power cycle, 1 watchdog in run, 2 watchdog in stop, 3 stop recovery.
    task automatic fire(input int s);
        @(posedge ref_clk);
        power_ok <= (s != 0);
        stop_mode <= (s == 2);
        wdt_timeout <= (s == 1 || s == 2);
        stop_recovery <= (s == 3);
        @(posedge ref_clk);
        power_ok <= 1'b1;
        wdt_timeout <= 1'b0;
        stop_recovery <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Main sequence of tests.
    initial begin
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        wait_exec();
        for (int i = 0; i < 11; i++) begin
            reg_read(d_addr[i], rd_val);
            compare8("default value", d_val[i], rd_val & d_mask[i]);
        end
        $display("test defaults done");
        rst_len = 0;
        pin_pulse(8'h03);
        repeat (20) @(posedge ref_clk);
        compare_bit("reset from short pulse", 1'b0, rst_len != 0);
        reg_write(8'h10, 8'hFF);
        reg_write(8'h20, 8'hA5);
        reg_write(8'hF6, 8'h12);
        pin_pulse(8'h05);
        wait_exec();
        reg_read(8'hF6, rd_val);
        compare8("port 2 mode", 8'hFF, rd_val);
        compare8("ctrl port 2 mode", 8'hFF, ctrl.p2_mode);
        reg_read(8'h20, rd_val);
        compare8("scratch kept", 8'hA5, rd_val);
        reg_read(8'h10, rd_val);
        compare8("pin cause", 8'h02, rd_val & 8'h02);
        $display("test pin filter done");
        reg_write(8'hF7, 8'h34);
        rst_len = 0;
        pin_pulse(8'h3C);
        repeat (30) @(posedge ref_clk);
        reg_write(8'hF6, 8'h55);
        wait_exec();
        compare_bit("reset stretched", 1'b1, rst_len >= 53);
        reg_read(8'hF6, rd_val);
        compare8("write in reset dropped", 8'hFF, rd_val);
        reg_read(8'hF7, rd_val);
        compare8("port 3 mode", 8'h00, rd_val);
        $display("test long pin done");
        for (int s = 0; s < 4; s++) begin
            reg_write(8'hF6, 8'h12);
            reg_write(8'h10, 8'hFF);
            rst_len = 0;
            fire(s);
            wait_exec();
            reg_read(8'hF6, rd_val);
            compare8("port 2 mode after source", s_p2[s], rd_val);
            reg_read(8'h10, rd_val);
            compare8("cause flag", s_cause[s], rd_val & s_cause[s]);
            compare_bit("hold length", 1'b1, rst_len >= 25);
        end
        reg_write(8'h11, 8'h00);
        rst_len = 0;
        fire(1);
        repeat (10) @(posedge ref_clk);
        compare_bit("wdt masked", 1'b0, rst_len != 0);
        $display("test sources done");
        print_verdict();
    end

    // Hang guard; a clean run takes well under a thousand clocks.
    initial begin
        #400000;
        bad_count++;
        print_verdict();
    end
endmodule
bind rsq_top rsq_top_chk #(.POR_HOLD_CYCLES(POR_HOLD_CYCLES)) u_chk (.ref_clk(ref_clk),
    .reset(reset), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
    .power_ok(power_ok), .stop_recovery(stop_recovery), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rst_int(rst_int), .exec_start(exec_start),
    .pc_vector(pc_vector), .strobes(strobes));
`default_nettype wire
